// file: hw/psc_pkg.sv
/*
 Constants, field layouts and carrier types for the parallel stack
 coordination block. Assumes a 40 MHz system clock and an APB master.
*/
// What this block does
// [R1] During init the phase clock pin is sensed: pulled low is secondary, open is primary.
// [R2] The sensed role is latched at init end and held until the next init.
// [R3] Secondaries run forced PWM unconditionally; host configures the primary for it.
// [R4] The switching clock is forwarded on the phase pin, about 140 degrees later.
// [R5] External sync or spread spectrum enters the primary only and follows the chain.
// [R6] The host never enables hiccup overcurrent protection inside a stack.
// [R7] The enable line is pulled low during start-up or fault; stack runs when released.
// [R8] An active fault keeps the enable line low for its whole duration.
// [R9] Current limit stays local; thermal, undervoltage, overvoltage pull the enable line.
// [R10] Thermal shutdown pulls enable only with standalone bit clear; released on recovery.
// [R11] The primary holds the loop control node low while enable is low.
// [R12] With enable high the primary drives the loop node; secondaries follow it.
// [R13] All devices pull power good low during init; secondaries release it afterwards.
// [R14] Only the primary drives power good from its window comparator.
// [R15] The primary releases power good after the ramp, with output inside the window.
// [R16] Secondaries detect the power good rising edge and then enable current sinking.
// [R17] Only the primary offers the serial register interface.
// [R18] Only the primary's voltage select pins set the default output voltage.
// [R19] Voltage scaling is commanded through the primary alone.
// [R20] Output discharge is always on in secondaries, selectable in the primary.
package psc_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int INIT_TIME_NS = 10000;
    localparam int INIT_CYC = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PHASE_DEG = 140;
    localparam int FULL_DEG = 360;
    localparam int SW_PERIOD_CYC = 40;
    localparam int SYNC_LOSS_CYC = 64;
    localparam int DVS_STEP_CYC = 40;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYC - 1);
    localparam logic [CNT_W-1:0] DVS_LAST = CNT_W'(DVS_STEP_CYC - 1);

    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_VOUT = 8'h08;

    localparam int CTRL_W = 4;
    localparam int CTRL_FORCED_PULSE_WIDTH_MODULATION = 0;
    localparam int CTRL_DISCH = 1;
    localparam int CTRL_STANDALONE = 2;
    localparam int CTRL_SSC = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h2;

    localparam int VOUT_W = 8;
    localparam int VSET_W = 3;

    typedef struct packed {
        logic tsd;
        logic undervoltage_lockout;
        logic overvoltage_lockout;
        logic ilim;
    } psc_fault_type;

    typedef struct packed {
        logic dvs_active;
        psc_fault_type fault;
        logic pg_line;
        logic en_line;
        logic run;
        logic primary;
    } psc_status_type;

    typedef enum logic [1:0] {
        ST_INIT = 2'b01,
        ST_RUN = 2'b10
    } psc_state_type;
endpackage

// file: hw/psc_top.sv
/*
 Stack coordination logic of one power module: role sensing, shared
 enable and power-good handshake, loop hand-off, phase clock chain and
 an APB register slave. Assumes all pins but the APB port are asynchronous to clk_sys_i
 and that open-drain lines have external pull-ups.
*/
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module psc_top #(
    parameter int SW_PERIOD = psc_pkg::SW_PERIOD_CYC,
    parameter int SYNC_LOSS = psc_pkg::SYNC_LOSS_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [psc_pkg::APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic phase_clk_i,
    output logic phase_clk_o,
    output logic phase_clk_oe_o,
    input wire logic clk_sel_i,
    input wire logic en_line_i,
    output logic en_line_o,
    output logic en_line_oe_o,
    input wire logic power_good_line_i,
    output logic power_good_line_o,
    output logic power_good_line_oe_o,
    input wire psc_pkg::psc_fault_type fault_i,
    input wire logic pg_window_ok_i,
    input wire logic ramp_done_i,
    input wire logic [psc_pkg::VSET_W-1:0] voltage_select_pins_i,
    output logic role_primary_o,
    output logic loop_hold_o,
    output logic loop_drive_o,
    output logic loop_follow_o,
    output logic switch_en_o,
    output logic ilim_clamp_o,
    output logic forced_pulse_width_modulation_o,
    output logic sink_en_o,
    output logic discharge_en_o,
    output logic serial_en_o,
    output logic dynamic_voltage_scaling_o,
    output logic [psc_pkg::VOUT_W-1:0] vout_code_o,
    output logic sw_pulse_o
);
    import psc_pkg::*;

    localparam int SYN_W = 10 + VSET_W;
    localparam logic [CNT_W-1:0] SW_LAST = CNT_W'(SW_PERIOD - 1);
    localparam logic [CNT_W-1:0] LOSS_CNT = CNT_W'(SYNC_LOSS);

    logic rst_meta;
    logic rst_n;
    logic [SYN_W-1:0] meta_reg;
    logic [SYN_W-1:0] pin_reg;
    logic role_s, sel_s, en_s, pg_s, win_s, ramp_s;
    psc_fault_type flt_s;
    logic [VSET_W-1:0] vset_s;
    logic sel_q, pg_q, sel_rise, pg_rise;
    psc_state_type state_reg;
    logic [CNT_W-1:0] init_cnt;
    logic init, prim, own_fault, en_pull, pg_pull, pg_seen_reg;
    logic [CTRL_W-1:0] ctrl_reg;
    logic [VOUT_W-1:0] vout_tgt_reg;
    logic [2:0] sel;
    logic acc, wr, bad;
    logic [31:0] rd_data;
    psc_status_type stat;
    logic [CNT_W-1:0] dvs_cnt, gap_cnt, int_cnt, int_last, per_cnt;
    logic [CNT_W-1:0] period_reg, phase_dly, dly_cnt, hi_cnt;
    logic [1:0] dither_reg;
    logic ext_on, int_tick, ref_edge, armed_reg, fire, sw_hi_reg;

    function automatic logic [2:0] reg_decode(input logic [APB_AW-1:0] a);
        reg_decode = {a == ADDR_VOUT, a == ADDR_STATUS, a == ADDR_CTRL};
    endfunction

    // Reset release through two stages
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            pin_reg <= '0;
        end else begin
            meta_reg <= {phase_clk_i, clk_sel_i, en_line_i, power_good_line_i,
                         fault_i, pg_window_ok_i, ramp_done_i,
                         voltage_select_pins_i};
            pin_reg <= meta_reg;
        end
    end
    assign {role_s, sel_s, en_s, pg_s, flt_s, win_s, ramp_s, vset_s} = pin_reg;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= 1'b0;
            pg_q <= 1'b0;
        end else begin
            sel_q <= sel_s;
            pg_q <= pg_s;
        end
    end
    assign sel_rise = sel_s & ~sel_q;
    assign pg_rise = pg_s & ~pg_q;

    // Role is taken once, at the end of init, while the pin is undriven
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_INIT;
            init_cnt <= '0;
            role_primary_o <= 1'b1;
        end else begin
            unique case (state_reg)
                ST_INIT: begin
                    init_cnt <= init_cnt + 1'b1;
                    if (init_cnt == INIT_LAST) begin
                        state_reg <= ST_RUN;
                        role_primary_o <= role_s; // see [R1] see [R2]
                    end
                end
                ST_RUN: state_reg <= ST_RUN;
            endcase
        end
    end
    assign init = state_reg == ST_INIT;
    assign prim = role_primary_o;

    assign own_fault = flt_s.tsd | flt_s.undervoltage_lockout | flt_s.overvoltage_lockout;
    // Current limit is deliberately absent: it must not stop the stack
    assign en_pull = init | flt_s.undervoltage_lockout | flt_s.overvoltage_lockout // see [R7] see [R8] see [R9]
                   | (flt_s.tsd & ~ctrl_reg[CTRL_STANDALONE]); // see [R10]
    assign pg_pull = init // see [R13]
                   | (prim & ~(ramp_s & win_s & en_s & ~own_fault)); // see [R14] see [R15]

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            en_line_o <= 1'b0;
            en_line_oe_o <= 1'b1;
            power_good_line_o <= 1'b0;
            power_good_line_oe_o <= 1'b1;
        end else begin
            en_line_o <= 1'b0;
            en_line_oe_o <= en_pull;
            power_good_line_o <= 1'b0;
            power_good_line_oe_o <= pg_pull;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            loop_hold_o <= 1'b1;
            loop_drive_o <= 1'b0;
            loop_follow_o <= 1'b0;
        end else begin
            loop_hold_o <= prim & (init | ~en_s); // see [R11]
            loop_drive_o <= prim & ~init & en_s; // see [R12]
            loop_follow_o <= ~prim & ~init & en_s; // see [R12]
        end
    end

    // Cleared whenever the stack drops, so a restart waits for a new edge
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pg_seen_reg <= 1'b0;
        end else if (init | ~en_s) begin
            pg_seen_reg <= 1'b0;
        end else if (~prim & pg_rise) begin
            pg_seen_reg <= 1'b1; // see [R16]
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            switch_en_o <= 1'b0;
            ilim_clamp_o <= 1'b0;
            forced_pulse_width_modulation_o <= 1'b0;
            sink_en_o <= 1'b0;
            discharge_en_o <= 1'b0;
            serial_en_o <= 1'b0;
        end else begin
            switch_en_o <= ~init & en_s & ~own_fault;
            ilim_clamp_o <= flt_s.ilim; // see [R9]
            forced_pulse_width_modulation_o <= ~prim | ctrl_reg[CTRL_FORCED_PULSE_WIDTH_MODULATION]; // see [R3]
            sink_en_o <= ~init & (prim | pg_seen_reg); // see [R16]
            discharge_en_o <= ~prim | ctrl_reg[CTRL_DISCH]; // see [R20]
            serial_en_o <= prim & ~init; // see [R17]
        end
    end

    // APB slave, one wait state; secondaries answer every access with error
    assign sel = reg_decode(paddr_i);
    assign acc = psel_i & penable_i & pready_o;
    assign bad = (sel == 3'b000) | ~prim | init; // see [R17]
    assign wr = acc & pwrite_i & ~bad;
    assign stat = '{dvs_active: dynamic_voltage_scaling_o, fault: flt_s,
                    pg_line: pg_s, en_line: en_s, run: ~init, primary: prim};

    always_comb begin
        rd_data = '0;
        if (sel[0]) begin
            rd_data = 32'(ctrl_reg);
        end else if (sel[1]) begin
            rd_data = 32'(stat);
        end else if (sel[2]) begin
            rd_data = 32'(vout_tgt_reg);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end else begin
            pready_o <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & bad;
            prdata_o <= (psel_i & penable_i & ~pready_o & ~bad) ? rd_data : '0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RST;
            vout_tgt_reg <= '0;
        end else if (init && init_cnt == INIT_LAST) begin
            vout_tgt_reg <= role_s ? VOUT_W'(vset_s) : '0; // see [R18]
        end else if (wr) begin
            if (sel[0]) begin
                ctrl_reg <= pwdata_i[CTRL_W-1:0];
            end
            if (sel[2]) begin
                vout_tgt_reg <= pwdata_i[VOUT_W-1:0]; // see [R19]
            end
        end
    end

    // Output code slews one step per tick toward the target
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            dvs_cnt <= '0;
            vout_code_o <= '0;
            dynamic_voltage_scaling_o <= 1'b0;
        end else if (init) begin
            dvs_cnt <= '0;
            vout_code_o <= role_s ? VOUT_W'(vset_s) : '0; // see [R18]
            dynamic_voltage_scaling_o <= 1'b0;
        end else begin
            dvs_cnt <= (dvs_cnt == DVS_LAST) ? '0 : dvs_cnt + 1'b1;
            dynamic_voltage_scaling_o <= vout_code_o != vout_tgt_reg;
            if (dvs_cnt == DVS_LAST) begin
                if (vout_code_o < vout_tgt_reg) begin
                    vout_code_o <= vout_code_o + 1'b1; // see [R19]
                end else if (vout_code_o > vout_tgt_reg) begin
                    vout_code_o <= vout_code_o - 1'b1;
                end
            end
        end
    end

    // External sync counts as present while its edges keep arriving
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            gap_cnt <= LOSS_CNT;
        end else if (sel_rise) begin
            gap_cnt <= '0;
        end else if (gap_cnt < LOSS_CNT) begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end
    assign ext_on = gap_cnt < LOSS_CNT;

    assign int_last = SW_LAST + {{(CNT_W-2){1'b0}},
                                 dither_reg & {2{ctrl_reg[CTRL_SSC]}}};
    assign int_tick = int_cnt >= int_last;
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            int_cnt <= '0;
            dither_reg <= '0;
        end else if (int_tick) begin
            int_cnt <= '0;
            dither_reg <= dither_reg + 1'b1; // see [R5]
        end else begin
            int_cnt <= int_cnt + 1'b1;
        end
    end

    // Secondaries only ever follow the chain, never their own oscillator
    assign ref_edge = (prim & ~ext_on) ? int_tick : sel_rise; // see [R5]

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt <= '0;
            period_reg <= SW_LAST + 1'b1;
        end else if (ref_edge) begin
            per_cnt <= '0;
            period_reg <= per_cnt + 1'b1;
        end else if (per_cnt != '1) begin
            per_cnt <= per_cnt + 1'b1;
        end
    end

    assign phase_dly = prim ? '0
        : CNT_W'(int'(period_reg) * PHASE_DEG / FULL_DEG); // see [R4]
    assign fire = armed_reg & (dly_cnt == phase_dly);

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
            dly_cnt <= '0;
        end else if (ref_edge) begin
            armed_reg <= 1'b1;
            dly_cnt <= '0;
        end else if (fire) begin
            armed_reg <= 1'b0;
        end else if (armed_reg) begin
            dly_cnt <= dly_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sw_hi_reg <= 1'b0;
            hi_cnt <= '0;
        end else if (fire) begin
            sw_hi_reg <= 1'b1;
            hi_cnt <= '0;
        end else if (sw_hi_reg) begin
            hi_cnt <= hi_cnt + 1'b1;
            if (hi_cnt >= (period_reg >> 1)) begin
                sw_hi_reg <= 1'b0;
            end
        end
    end

    // Pin stays undriven during init so the strap can be sensed
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            phase_clk_o <= 1'b0;
            phase_clk_oe_o <= 1'b0;
            sw_pulse_o <= 1'b0;
        end else begin
            phase_clk_o <= sw_hi_reg; // see [R4]
            phase_clk_oe_o <= ~init; // see [R1]
            sw_pulse_o <= fire;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    chk_sense_undriven: assert property (init |=> !phase_clk_oe_o) // see [R1]
        else $error("phase pin driven during init");
    chk_role_held: assert property (!init && $past(!init) |-> $stable(prim)) // see [R2]
        else $error("role changed after init");
    chk_sec_forced_pulse_width_modulation: assert property (!init && !prim |=> forced_pulse_width_modulation_o) // see [R3]
        else $error("secondary not in forced pwm");
    chk_en_startup: assert property (init |=> en_line_oe_o) // see [R7]
        else $error("enable not pulled during init");
    chk_en_fault: assert property (flt_s.undervoltage_lockout |=> en_line_oe_o) // see [R8]
        else $error("enable released during fault");
    chk_ilim_local: assert property (!init && flt_s.ilim && !own_fault // see [R9]
        |=> !en_line_oe_o) else $error("current limit pulled enable");
    chk_tsd_standalone: assert property (!init && flt_s.tsd // see [R10]
        && ctrl_reg[CTRL_STANDALONE] && !flt_s.undervoltage_lockout && !flt_s.overvoltage_lockout
        |=> !en_line_oe_o) else $error("standalone thermal pulled enable");
    chk_loop_hold: assert property (prim && !en_s |=> loop_hold_o // see [R11]
        && !loop_drive_o) else $error("loop node not held");
    chk_pg_secondary: assert property (!init && !prim // see [R13]
        |=> !power_good_line_oe_o) else $error("secondary drives power good");
    chk_pg_release: assert property (!init && prim && !ramp_s // see [R15]
        |=> power_good_line_oe_o) else $error("power good released early");
    chk_sec_discharge: assert property (!init && !prim |=> discharge_en_o) // see [R20]
        else $error("secondary discharge off");

    cov_secondary: cover property (!init && !prim && pg_rise);
    cov_ext_sync: cover property (prim && ext_on && fire);
    cov_dvs: cover property (dynamic_voltage_scaling_o && !init);
endmodule

// file: test/parallel_stack_coordination_tb_top.sv
/*
 Self-checking bench for the stack coordination block: one block, one
 peer model, pulled-up shared lines and an APB master.
 Assumes the block answers APB with one wait state as handed over.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) check_val(n, 32'(e), 32'(g))
module parallel_stack_coordination_tb_top;
    import psc_pkg::*;
    localparam int SWP = 40;
    logic clk_sys_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0;
    logic pwrite_i = 0, clk_sel_i = 0, sync_on = 0, strap_sec = 0;
    logic pg_ok = 0, ramp = 0, pg_hold = 0, rerr;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, rdata;
    logic [2:0] vsel = 3'h5;
    psc_fault_type fault = 4'h0, peer_fault = 4'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, phase_clk_o, phase_clk_oe_o, en_oe, pg_oe;
    logic en_pull, pg_pull, role, hold, drive, sw_en, clamp, forced_pulse_width_modulation, sink;
    logic disch, serial, dynamic_voltage_scaling, sw_pulse_o, en_o, pg_o, follow;
    logic [7:0] vout;
    int mismatches = 0, n_checks = 0, cyc = 0, p, d;
    wire phase_pin = phase_clk_oe_o ? phase_clk_o : !strap_sec;
    wire en_line = !((en_oe && !en_o) || en_pull);
    wire pg_line = !((pg_oe && !pg_o) || pg_pull || pg_hold);

    always #12.5 clk_sys_i = ~clk_sys_i;
    // Chain clock of 200 ns, standing low while switched off
    initial begin
        #7;
        forever begin
            #100;
            clk_sel_i = sync_on ? ~clk_sel_i : 1'b0;
        end
    end

    psc_top #(.SW_PERIOD(SWP), .SYNC_LOSS(64)) i_psc_top (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .phase_clk_i(phase_pin),
        .phase_clk_o(phase_clk_o), .phase_clk_oe_o(phase_clk_oe_o),
        .clk_sel_i(clk_sel_i), .en_line_i(en_line), .en_line_o(en_o),
        .en_line_oe_o(en_oe), .power_good_line_i(pg_line),
        .power_good_line_o(pg_o), .power_good_line_oe_o(pg_oe),
        .fault_i(fault), .pg_window_ok_i(pg_ok), .ramp_done_i(ramp),
        .voltage_select_pins_i(vsel), .role_primary_o(role),
        .loop_hold_o(hold), .loop_drive_o(drive), .loop_follow_o(follow),
        .switch_en_o(sw_en), .ilim_clamp_o(clamp),
        .forced_pulse_width_modulation_o(forced_pulse_width_modulation), .sink_en_o(sink),
        .discharge_en_o(disch), .serial_en_o(serial),
        .dynamic_voltage_scaling_o(dynamic_voltage_scaling), .vout_code_o(vout),
        .sw_pulse_o(sw_pulse_o));

    psc_peer_model #(.INIT_CYC(600)) i_psc_peer_model (
        .clk_i(clk_sys_i), .rst_n_i(rst_n_i), .fault_i(peer_fault),
        .en_pull_o(en_pull), .pg_pull_o(pg_pull));

    task automatic check_val(input string n, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= dat;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        rdata = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Cycles spanned by n consecutive own switching periods
    task automatic period(input int n, output int q);
        int k;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (sw_pulse_o !== 1'b1 && k < 200);
        q = 0;
        repeat (n) begin
            do begin
                @(posedge clk_sys_i);
                q++;
            end while (sw_pulse_o !== 1'b1 && q < 800);
        end
    endtask

    task automatic set_fault(input logic [3:0] f);
        @(posedge clk_sys_i);
        fault <= f;
        wt(4);
    endtask

    task automatic do_reset(input logic sec);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        strap_sec <= sec;
        sync_on <= sec;
        wt(3);
        `CHK("en oe in reset", 1, en_oe);
        `CHK("pg oe in reset", 1, pg_oe);
        `CHK("loop hold in reset", 1, hold);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        wt(410);
    endtask

    initial begin
        do_reset(1'b0);
        `CHK("role", 1, role);
        `CHK("serial", 1, serial);
        `CHK("en oe after init", 0, en_oe);
        `CHK("hold while en low", 1, hold);
        `CHK("drive while en low", 0, drive);
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK("ctrl reset", CTRL_RST, rdata[3:0]);
        `CHK("ctrl err", 0, rerr);
        apb(1'b1, ADDR_CTRL, 32'h1);
        wt(2);
        `CHK("forced_pulse_width_modulation set", 1, forced_pulse_width_modulation);
        `CHK("discharge off", 0, disch);
        apb(1'b0, ADDR_VOUT, 32'h0);
        `CHK("vout default", vsel, rdata[7:0]);
        apb(1'b0, 8'h0C, 32'h0);
        `CHK("unmapped err", 1, rerr);
        $display("test primary registers done");
        for (int k = 0; k < 400 && en_line !== 1'b1; k++) wt(0);
        wt(4);
        `CHK("drive en high", 1, drive);
        `CHK("hold en high", 0, hold);
        `CHK("follow primary", 0, follow);
        `CHK("switching", 1, sw_en);
        `CHK("pg before ramp", 1, pg_oe);
        @(posedge clk_sys_i);
        ramp <= 1'b1;
        wt(4);
        `CHK("pg outside window", 1, pg_oe);
        @(posedge clk_sys_i);
        pg_ok <= 1'b1;
        wt(4);
        `CHK("pg released", 0, pg_oe);
        // Primary, run, enable and power good set; no fault, no slew
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("status", 32'h0F, rdata);
        @(posedge clk_sys_i);
        pg_ok <= 1'b0;
        wt(4);
        `CHK("pg window lost", 1, pg_oe);
        $display("test handshake done");
        for (int i = 1; i < 4; i++) begin
            set_fault(4'h1 << i);
            `CHK("fault pulls en", 1, en_oe);
            `CHK("fault stops", 0, sw_en);
            wt(20);
            `CHK("fault holds en", 1, en_oe);
            set_fault(4'h0);
            `CHK("fault recovered", 0, en_oe);
        end
        set_fault(4'h1);
        `CHK("ilim en kept", 0, en_oe);
        `CHK("ilim clamp", 1, clamp);
        `CHK("ilim switching", 1, sw_en);
        set_fault(4'h0);
        apb(1'b1, ADDR_CTRL, 32'h5);
        set_fault(4'h8);
        `CHK("standalone tsd", 0, en_oe);
        set_fault(4'h0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        @(posedge clk_sys_i);
        peer_fault <= 4'h4;
        wt(4);
        `CHK("peer fault hold", 1, hold);
        `CHK("peer fault stop", 0, sw_en);
        @(posedge clk_sys_i);
        peer_fault <= 4'h0;
        $display("test faults done");
        apb(1'b1, ADDR_VOUT, 32'h7);
        wt(2);
        `CHK("dvs active", 1, dynamic_voltage_scaling);
        wt(120);
        `CHK("vout reached", 7, vout);
        `CHK("dvs idle", 0, dynamic_voltage_scaling);
        period(1, p);
        `CHK("internal period", SWP, p);
        `CHK("phase pin driven", 1, phase_clk_oe_o);
        apb(1'b1, ADDR_CTRL, 32'h9);
        // Four periods in a row carry each dither step 0..3 once
        period(4, p);
        `CHK("ssc period", 4 * SWP + 6, p);
        @(posedge clk_sys_i);
        sync_on <= 1'b1;
        wt(100);
        period(1, p);
        `CHK("sync period", 8, p);
        $display("test primary clocking done");
        pg_hold <= 1'b1;
        do_reset(1'b1);
        `CHK("role sec", 0, role);
        `CHK("forced_pulse_width_modulation sec", 1, forced_pulse_width_modulation);
        `CHK("discharge sec", 1, disch);
        `CHK("serial sec", 0, serial);
        `CHK("vsel ignored", 0, vout);
        `CHK("pg sec released", 0, pg_oe);
        apb(1'b1, ADDR_VOUT, 32'h7);
        `CHK("sec apb err", 1, rerr);
        wt(4);
        `CHK("sec no dvs", 0, dynamic_voltage_scaling);
        period(1, p);
        `CHK("sec period", 8, p);
        while (clk_sel_i === 1'b1) @(posedge clk_sys_i);
        while (clk_sel_i !== 1'b1) @(posedge clk_sys_i);
        d = 0;
        while (sw_pulse_o !== 1'b1 && d < 50) begin
            @(posedge clk_sys_i);
            d++;
        end
        // Sync, edge detect and output register add four cycles
        `CHK("phase offset", 4 + 8 * PHASE_DEG / FULL_DEG, d);
        `CHK("role held", 0, role);
        for (int k = 0; k < 400 && en_line !== 1'b1; k++) wt(0);
        wt(4);
        `CHK("follow sec", 1, follow);
        `CHK("sink before pg", 0, sink);
        @(posedge clk_sys_i);
        pg_hold <= 1'b0;
        wt(4);
        `CHK("sink after pg", 1, sink);
        @(posedge clk_sys_i);
        peer_fault <= 4'h2;
        wt(4);
        `CHK("sink en low", 0, sink);
        $display("test secondary done");
        end_of_test();
    end
endmodule

// file: test/psc_peer_model.sv
/*
 Behavioural peer module of a stack, seen from the coordination block.
 Assumes its pulls are wired onto the pulled-up shared enable and
 power-good lines by the bench, and that it shares the bench reset.
*/
`timescale 1ns/1ps
module psc_peer_model #(
    parameter int INIT_CYC = 600
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire psc_pkg::psc_fault_type fault_i,
    output logic en_pull_o,
    output logic pg_pull_o
);
    import psc_pkg::*;
    int init_cnt;
    logic init_done;

    // Longer than the block's own init, so the stack waits on the peer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_cnt <= 0;
            init_done <= 1'b0;
        end else if (init_cnt < INIT_CYC) begin
            init_cnt <= init_cnt + 1;
        end else begin
            init_done <= 1'b1;
        end
    end

    // No hiccup mode here: a current limit never touches the lines
    assign en_pull_o = !init_done || fault_i.tsd || fault_i.undervoltage_lockout ||
        fault_i.overvoltage_lockout;
    // A secondary peer lets go of power good once initialised
    assign pg_pull_o = !init_done;
endmodule
